// File: pkg/fccs_pkg.sv
// Constants and carrier types for the flash CRC check sequencer (host end).
`default_nettype none
package fccs_pkg;
  localparam int ADDR_W        = 23;   // Word address pins A[max:0].
  localparam int CLK_PERIOD_NS = 10;
  // Bus cycle times (plain defaults, in ns).
  localparam int T_SETUP_NS = 20;
  localparam int T_WP_NS    = 50;
  localparam int T_HOLD_NS  = 30;
  localparam int T_ACC_NS   = 80;
  localparam int SYNC_CYC   = 2;
  localparam logic [3:0] SETUP_CYC =
    4'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] WP_CYC =
    4'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] HOLD_CYC =
    4'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] RD_CYC =
    4'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_CYC);
  // Command addresses and codes.
  localparam logic [31:0] UNLK1_WADDR = 32'h0000_0555;
  localparam logic [31:0] UNLK2_WADDR = 32'h0000_02aa;
  localparam logic [31:0] UNLK1_BADDR = 32'h0000_0aaa;
  localparam logic [31:0] UNLK2_BADDR = 32'h0000_0555;
  localparam logic [15:0] UNLK1_DATA  = 16'h00aa;
  localparam logic [15:0] UNLK2_DATA  = 16'h0055;
  localparam logic [15:0] EXT_CODE    = 16'h00eb;
  localparam logic [15:0] CRC_SUBOP   = 16'h0027;
  localparam logic [15:0] CONFIRM     = 16'h0029;
  localparam logic [15:0] READ_RESET  = 16'h00f0;
  localparam logic [15:0] CNT_RANGE_W = 16'h000a;
  localparam logic [15:0] CNT_RANGE_B = 16'h0015;
  localparam logic [15:0] CNT_CHIP_W  = 16'h0004;
  localparam logic [15:0] CNT_CHIP_B  = 16'h0009;
  localparam logic [15:0] OPT_RANGE   = 16'hfffe;
  localparam logic [15:0] OPT_CHIP    = 16'hffff;
  localparam logic [15:0] RSVD_WORD   = 16'h0000;
  // Sequence steps; steps 5 to 15 are word-wide and split in byte mode.
  localparam logic [4:0] STEP_COUNT    = 5'h04;
  localparam logic [4:0] STEP_OPTION   = 5'h05;
  localparam logic [4:0] STEP_LAST_CRC = 5'h09;
  localparam logic [4:0] STEP_LAST_PAY = 5'h0f;
  localparam logic [4:0] STEP_CONFIRM  = 5'h10;
  // Polled status bit positions.
  localparam int TOGGLE_BIT = 6;
  localparam int FAIL_BIT   = 5;

  typedef struct packed {
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic              byte_n;
    logic [ADDR_W-1:0] addr;
    logic [15:0]       dq_out;
    logic [15:0]       dq_oe_n;   // Low while the host drives that bit.
  } fccs_pins_t;

  typedef struct packed {
    logic        chip;        // One: whole array, zero: byte range.
    logic        byte_mode;
    logic [63:0] crc;
    logic [31:0] start_addr;
    logic [31:0] end_addr;    // Inclusive.
  } fccs_req_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic pass;
    logic fail;
    logic refused;
  } fccs_stat_t;
endpackage : fccs_pkg
`default_nettype wire

// File: rtl/fccs_bus_cycle.sv
// One asynchronous flash bus write or read cycle with timed strobes.
`default_nettype none
module fccs_bus_cycle
  import fccs_pkg::*;
(
  input  wire logic               i_ref_clk,
  input  wire logic               i_srst,
  input  wire logic               i_req,
  input  wire logic               i_write,
  input  wire logic               i_byte_mode,
  input  wire logic [31:0]        i_addr,
  input  wire logic [15:0]        i_wdata,
  input  wire logic [15:0]        i_dq_in,
  output var  fccs_pkg::fccs_pins_t o_pins,
  output logic                    o_done,
  output logic [15:0]             o_rdata
);
  typedef enum logic [1:0] {
    BC_IDLE  = 2'b00,
    BC_SETUP = 2'b01,
    BC_PULSE = 2'b10,
    BC_HOLD  = 2'b11
  } fccs_bc_t;

  fccs_bc_t    state_reg;
  logic [3:0]  cnt_reg;
  logic        write_reg;
  logic [15:0] dq_s1_reg;
  logic [15:0] dq_s2_reg;
  wire         phase_end = (cnt_reg == 4'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Data pins come from the device's own timing, so two flops first.
  always_ff @(posedge i_ref_clk) begin
    dq_s1_reg <= i_dq_in;
    dq_s2_reg <= dq_s1_reg;
  end

  // Phase sequencer; read pulse covers access time plus the synchroniser.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      state_reg <= BC_IDLE;
      cnt_reg   <= 4'h0;
      write_reg <= 1'b0;
    end else if (state_reg == BC_IDLE) begin
      if (i_req) begin
        state_reg <= BC_SETUP;
        cnt_reg   <= SETUP_CYC - 4'h1;
        write_reg <= i_write;
      end
    end else if (!phase_end) begin
      cnt_reg <= cnt_reg - 4'h1;
    end else begin
      unique case (state_reg)
        BC_SETUP: begin
          state_reg <= BC_PULSE;
          cnt_reg   <= (write_reg ? WP_CYC : RD_CYC) - 4'h1;
        end
        BC_PULSE: begin
          state_reg <= BC_HOLD;
          cnt_reg   <= HOLD_CYC - 4'h1;
        end
        BC_HOLD:  state_reg <= BC_IDLE;
        BC_IDLE:  state_reg <= BC_IDLE;
      endcase
    end
  end

  // Pin drive. In byte mode the top data pin carries the lowest byte
  // address line and the upper lanes float, so a read still drives it.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_pins  <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, byte_n: 1'b1,
                   addr: '0, dq_out: 16'h0000, dq_oe_n: 16'hffff};
      o_done  <= 1'b0;
      o_rdata <= 16'h0000;
    end else begin
      o_done <= 1'b0;
      if (state_reg == BC_IDLE && i_req) begin
        o_pins.ce_n   <= 1'b0;
        o_pins.byte_n <= !i_byte_mode;
        if (i_byte_mode) begin
          o_pins.addr    <= i_addr[ADDR_W:1];
          o_pins.dq_out  <= {i_addr[0], 7'h00, i_wdata[7:0]};
          o_pins.dq_oe_n <= i_write ? 16'h7f00 : 16'h7fff;
        end else begin
          o_pins.addr    <= i_addr[ADDR_W-1:0];
          o_pins.dq_out  <= i_wdata;
          o_pins.dq_oe_n <= i_write ? 16'h0000 : 16'hffff;
        end
      end else if (state_reg == BC_SETUP && phase_end) begin
        o_pins.we_n <= !write_reg;
        o_pins.oe_n <= write_reg;
      end else if (state_reg == BC_PULSE && phase_end) begin
        o_pins.we_n <= 1'b1;
        o_pins.oe_n <= 1'b1;
        if (!write_reg) begin
          o_rdata <= dq_s2_reg;
        end
      end else if (state_reg == BC_HOLD && phase_end) begin
        o_pins.ce_n    <= 1'b1;
        o_pins.dq_oe_n <= 16'hffff;
        o_done         <= 1'b1;
      end
    end
  end
endmodule : fccs_bus_cycle
`default_nettype wire

// File: rtl/fccs_host.sv
// Host sequencer that issues the flash CRC check and polls its verdict.
`default_nettype none
module fccs_host
  import fccs_pkg::*;
(
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_srst,
  input  wire logic                 i_start,
  input  wire fccs_pkg::fccs_req_t  i_req,
  input  wire logic [15:0]          i_dq_in,
  output var  fccs_pkg::fccs_pins_t o_pins,
  output var  fccs_pkg::fccs_stat_t o_status
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_WRITE = 3'b001,
    ST_WWAIT = 3'b010,
    ST_POLL  = 3'b011,
    ST_PWAIT = 3'b100,
    ST_ABORT = 3'b101,
    ST_AWAIT = 3'b110
  } fccs_st_t;

  fccs_st_t    state_reg;
  fccs_req_t   req_reg;
  logic [4:0]  step_reg;
  logic        half_reg;
  logic        have_prev_reg;
  logic        prev_tog_reg;
  logic        fail_seen_reg;
  logic        bus_req;
  logic        bus_write;
  logic [31:0] bus_addr;
  logic [15:0] bus_wdata;
  logic        bus_done;
  logic [15:0] bus_rdata;

  // Payload word for steps 5 to 15; used by both word and byte layouts.
  function automatic logic [15:0] fccs_pay_word(input logic [4:0] step,
                                                input fccs_req_t r);
    logic [15:0] w;
    w = RSVD_WORD;
    unique case (step)
      5'h05: w = r.chip ? OPT_CHIP : OPT_RANGE;
      5'h06: w = r.crc[15:0];
      5'h07: w = r.crc[31:16];
      5'h08: w = r.crc[47:32];
      5'h09: w = r.crc[63:48];
      5'h0a: w = r.start_addr[15:0];
      5'h0b: w = r.start_addr[31:16];
      5'h0d: w = r.end_addr[15:0];
      5'h0e: w = r.end_addr[31:16];
      default: w = RSVD_WORD;
    endcase
    return w;
  endfunction : fccs_pay_word

  ////////////////////////////////////////////////////////////////////////////
  // Address and data of the current write; byte mode splits words low first.
  always_comb begin
    logic [15:0] pay;
    logic [31:0] woff;
    pay       = fccs_pay_word(step_reg, req_reg);
    woff      = (step_reg == STEP_OPTION) ? 32'h0 :
                32'(step_reg - STEP_OPTION);
    bus_addr  = 32'h0;
    bus_wdata = RSVD_WORD;
    bus_write = (state_reg != ST_POLL);
    if (state_reg == ST_ABORT) begin
      bus_wdata = READ_RESET;
    end else if (state_reg == ST_WRITE) begin
      unique case (step_reg)
        5'h00: begin
          bus_addr  = req_reg.byte_mode ? UNLK1_BADDR : UNLK1_WADDR;
          bus_wdata = UNLK1_DATA;
        end
        5'h01: begin
          bus_addr  = req_reg.byte_mode ? UNLK2_BADDR : UNLK2_WADDR;
          bus_wdata = UNLK2_DATA;
        end
        5'h02: bus_wdata = EXT_CODE;
        5'h03: bus_wdata = CRC_SUBOP;
        5'h04: bus_wdata = req_reg.chip ?
          (req_reg.byte_mode ? CNT_CHIP_B : CNT_CHIP_W) :
          (req_reg.byte_mode ? CNT_RANGE_B : CNT_RANGE_W);
        5'h10: bus_wdata = CONFIRM;
        default: begin
          if (req_reg.byte_mode) begin
            bus_addr  = {woff[30:0], half_reg};
            bus_wdata = half_reg ? {8'h00, pay[15:8]} :
                                   {8'h00, pay[7:0]};
          end else begin
            bus_addr  = woff;
            bus_wdata = pay;
          end
        end
      endcase
    end
  end

  assign bus_req = (state_reg == ST_WRITE) || (state_reg == ST_POLL) ||
                   (state_reg == ST_ABORT);

  fccs_bus_cycle u_bus (
    .i_ref_clk   (i_ref_clk),
    .i_srst      (i_srst),
    .i_req       (bus_req),
    .i_write     (bus_write),
    .i_byte_mode (req_reg.byte_mode),
    .i_addr      (bus_addr),
    .i_wdata     (bus_wdata),
    .i_dq_in     (i_dq_in),
    .o_pins      (o_pins),
    .o_done      (bus_done),
    .o_rdata     (bus_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence. A start while busy is ignored; the request is latched
  // so the user side may change its inputs during the check.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      state_reg <= ST_IDLE;
      req_reg   <= '0;
      step_reg  <= 5'h00;
      half_reg  <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          // A range whose end is not above its start would do nothing.
          if (i_start && (i_req.chip ||
              i_req.end_addr > i_req.start_addr)) begin
            state_reg <= ST_WRITE;
            req_reg   <= i_req;
            step_reg  <= 5'h00;
            half_reg  <= 1'b0;
          end
        end
        ST_WRITE: state_reg <= ST_WWAIT;
        ST_WWAIT: begin
          if (bus_done) begin
            state_reg <= ST_WRITE;
            if (req_reg.byte_mode && step_reg > STEP_COUNT &&
                step_reg < STEP_CONFIRM && !half_reg) begin
              half_reg <= 1'b1;
            end else begin
              half_reg <= 1'b0;
              if (step_reg == STEP_CONFIRM) begin
                state_reg <= ST_POLL;
              end else if (req_reg.chip && step_reg == STEP_LAST_CRC) begin
                step_reg <= STEP_CONFIRM;
              end else begin
                step_reg <= step_reg + 5'h01;
              end
            end
          end
        end
        ST_POLL: state_reg <= ST_PWAIT;
        ST_PWAIT: begin
          if (bus_done) begin
            if (have_prev_reg &&
                prev_tog_reg == bus_rdata[TOGGLE_BIT]) begin
              state_reg <= bus_rdata[FAIL_BIT] ? ST_ABORT : ST_IDLE;
            end else if (fail_seen_reg && bus_rdata[FAIL_BIT]) begin
              state_reg <= ST_ABORT;
            end else begin
              state_reg <= ST_POLL;
            end
          end
        end
        ST_ABORT: state_reg <= ST_AWAIT;
        ST_AWAIT: if (bus_done) state_reg <= ST_IDLE;
        default:  state_reg <= ST_IDLE;
      endcase
    end
  end

  // Toggle tracking: the toggle bit stops when ready; the fail bit seen
  // while still toggling is confirmed by one more read, as it may race.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || state_reg == ST_IDLE) begin
      have_prev_reg <= 1'b0;
      prev_tog_reg  <= 1'b0;
      fail_seen_reg <= 1'b0;
    end else if (state_reg == ST_PWAIT && bus_done) begin
      have_prev_reg <= 1'b1;
      prev_tog_reg  <= bus_rdata[TOGGLE_BIT];
      fail_seen_reg <= bus_rdata[FAIL_BIT];
    end
  end

  // User status; pass and fail hold until the next start while idle, accepted or refused.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_status <= '0;
    end else begin
      o_status.done <= 1'b0;
      if (state_reg == ST_IDLE && i_start) begin
        if (i_req.chip || i_req.end_addr > i_req.start_addr) begin
          o_status <= '{busy: 1'b1, done: 1'b0, pass: 1'b0, fail: 1'b0,
                        refused: 1'b0};
        end else begin
          o_status <= '{busy: 1'b0, done: 1'b1, pass: 1'b0, fail: 1'b0,
                        refused: 1'b1};
        end
      end else if (state_reg == ST_PWAIT && bus_done && have_prev_reg &&
                   prev_tog_reg == bus_rdata[TOGGLE_BIT] &&
                   !bus_rdata[FAIL_BIT]) begin
        o_status.busy <= 1'b0;
        o_status.done <= 1'b1;
        o_status.pass <= 1'b1;
      end else if (state_reg == ST_AWAIT && bus_done) begin
        o_status.busy <= 1'b0;
        o_status.done <= 1'b1;
        o_status.fail <= 1'b1;
      end
    end
  end
endmodule : fccs_host
`default_nettype wire

// File: tb/fccs_flash_model.sv
// Behavioural flash device: logs writes, runs the check, answers polls.
`default_nettype none
module fccs_flash_model
  import fccs_pkg::*;
(
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_clr,
  input  wire fccs_pkg::fccs_pins_t i_pins,
  input  wire logic [63:0]          i_good_crc,
  output logic [15:0]               o_dq
);
  timeunit 1ns;
  timeprecision 1ps;
  import fccs_pkg::*;
  localparam int BUSY_CYC = 20;
  logic [31:0] log_a [64];
  logic [15:0] log_d [64];
  int          n_wr;
  int          busy_cnt;
  logic        we_q, oe_q, tog, err;
  logic [63:0] crc_rx;
  logic [31:0] a;
  logic [15:0] d;
  logic [15:0] stat;
  logic [15:0] pat;
  // In byte mode the top data pin is the lowest address line.
  assign a = i_pins.byte_n ? 32'(i_pins.addr)
                           : {8'h0, i_pins.addr, i_pins.dq_out[15]};
  assign d = i_pins.byte_n ? i_pins.dq_out : {8'h0, i_pins.dq_out[7:0]};
  assign stat = (busy_cnt != 0 || err) ? {9'h0, tog, err, 5'h0} : 16'h0;
  // A write lands at the rising write strobe; the check runs after confirm.
  always_ff @(posedge i_ref_clk) begin
    we_q <= i_pins.we_n;
    oe_q <= i_pins.oe_n;
    // A fixed start keeps the floating lanes from staying unknown.
    pat  <= i_clr ? 16'h5a5a : ~pat;
    if (i_clr) begin
      n_wr     <= 0;
      busy_cnt <= 0;
      err      <= 1'b0;
      tog      <= 1'b0;
      crc_rx   <= 64'h0;
    end else if (i_pins.we_n && !we_q && !i_pins.ce_n) begin
      log_a[n_wr] <= a;
      log_d[n_wr] <= d;
      n_wr        <= n_wr + 1;
      if (i_pins.byte_n && a >= 1 && a <= 4)
        crc_rx[16*(a-1)+:16] <= d;
      if (!i_pins.byte_n && a >= 2 && a <= 9)
        crc_rx[8*(a-2)+:8] <= d[7:0];
      if (a == 0 && d[7:0] == 8'h29)
        busy_cnt <= BUSY_CYC;
      if (a == 0 && d[7:0] == 8'hf0)
        err <= 1'b0;
    end else if (busy_cnt == 1) begin
      busy_cnt <= 0;
      // The bench supplies the array's true CRC in place of a computation.
      err      <= (crc_rx !== i_good_crc);
    end else if (busy_cnt > 1) begin
      busy_cnt <= busy_cnt - 1;
    end
    if (i_pins.oe_n && !oe_q && !i_pins.ce_n && !i_clr)
      tog <= ~tog;
  end
  // Undriven pins show a changing pattern so a stale value never passes.
  always_comb begin
    for (int b = 0; b < 16; b++) begin
      if (!i_pins.dq_oe_n[b]) o_dq[b] = i_pins.dq_out[b];
      else if (!i_pins.ce_n && !i_pins.oe_n) o_dq[b] = stat[b];
      else o_dq[b] = pat[b];
    end
  end
endmodule : fccs_flash_model
`default_nettype wire

// File: tb/fccs_host_props.sv
// Checker for the host sequencer's flash strobes and status handshake.
`default_nettype none
module fccs_host_props
  import fccs_pkg::*;
(
  input wire logic                 i_ref_clk,
  input wire logic                 i_srst,
  input wire logic                 i_start,
  input wire fccs_pkg::fccs_req_t  i_req,
  input wire logic [15:0]          i_dq_in,
  input wire fccs_pkg::fccs_pins_t o_pins,
  input wire fccs_pkg::fccs_stat_t o_status
);
  timeunit 1ns;
  timeprecision 1ps;
  logic take;
  logic bad_rng;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);
  // A start only counts while idle; the done cycle is left out on purpose.
  assign take    = i_start && !o_status.busy && !o_status.done;
  assign bad_rng = !i_req.chip && (i_req.end_addr <= i_req.start_addr);
  ////////////////////////////////////////////////////////////
  we_in_ce_a: assert property (!o_pins.we_n |-> !o_pins.ce_n)
    else $error("write strobe outside chip select");
  no_clash_a: assert property (o_pins.we_n || o_pins.oe_n)
    else $error("read and write strobes low together");
  we_width_a: assert property ($fell(o_pins.we_n) |->
    (!o_pins.we_n)[*5] ##1 o_pins.we_n)
    else $error("write strobe width wrong");
  we_setup_a: assert property ($fell(o_pins.we_n) |->
    !$past(o_pins.ce_n, 2))
    else $error("write strobe setup too short");
  we_hold_a: assert property ($rose(o_pins.we_n) |->
    (!o_pins.ce_n)[*3] ##1 o_pins.ce_n)
    else $error("chip select hold wrong");
  addr_hold_a: assert property (!o_pins.ce_n && !$past(o_pins.ce_n) |->
    $stable(o_pins.addr))
    else $error("address moved inside a bus cycle");
  refuse_a: assert property (take && bad_rng |=>
    o_status.done && o_status.refused && o_pins.ce_n)
    else $error("bad range not refused");
  busy_a: assert property (take && !bad_rng |=>
    o_status.busy && !o_status.done)
    else $error("accepted start did not raise busy");
  done_a: assert property (o_status.done |=> !o_status.done)
    else $error("done longer than one cycle");
  verdict_a: assert property (o_status.done |->
    $onehot({o_status.pass, o_status.fail, o_status.refused}))
    else $error("verdict not exactly one of three");
  byte_pins_a: assert property (!o_pins.byte_n |->
    &o_pins.dq_oe_n[14:8])
    else $error("upper data pins driven in byte mode");
endmodule : fccs_host_props

bind fccs_host fccs_host_props u_props (.i_ref_clk(i_ref_clk),
  .i_srst(i_srst), .i_start(i_start), .i_req(i_req), .i_dq_in(i_dq_in),
  .o_pins(o_pins), .o_status(o_status));
`default_nettype wire

// File: tb/fccs_host_tb.sv
// Self-checking bench for the host sequencer against a flash model.
`default_nettype none
module fccs_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fccs_pkg::*;
  typedef struct packed {
    fccs_req_t  rq;
    logic       good;
    logic [2:0] ex;   // Pass, fail, refused.
  } fccs_row_t;
  logic       ref_clk, srst, start, clr;
  fccs_req_t  req;
  fccs_pins_t pins;
  fccs_stat_t stat;
  logic [15:0] dq;
  logic [63:0] good;
  logic [31:0] ea [$];
  logic [15:0] ed [$];
  fccs_row_t   rows [8];
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  fccs_host DUT (.i_ref_clk(ref_clk), .i_srst(srst), .i_start(start),
    .i_req(req), .i_dq_in(dq), .o_pins(pins), .o_status(stat));
  fccs_flash_model MDL (.i_ref_clk(ref_clk), .i_clr(clr), .i_pins(pins),
    .i_good_crc(good), .o_dq(dq));
  ////////////////////////////////////////////////////////////
  // Free-running clock and a ceiling well above the longest run.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic chk(string nm, logic [63:0] got, logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic put(logic [31:0] a, logic [15:0] d);
    ea.push_back(a);
    ed.push_back(d);
  endtask : put
  // A word-wide step goes out as two bytes, low first, in byte mode.
  task automatic putw(logic [31:0] w, logic [15:0] d, logic b);
    if (b) begin
      put(2 * w, 16'(d[7:0]));
      put(2 * w + 1, 16'(d[15:8]));
    end else put(w, d);
  endtask : putw
  task automatic build(fccs_req_t r, logic fl);
    logic b;
    b = r.byte_mode;
    ea.delete();
    ed.delete();
    put(b ? 32'haaa : 32'h555, 16'haa);
    put(b ? 32'h555 : 32'h2aa, 16'h55);
    put(0, 16'heb);
    put(0, 16'h27);
    put(0, r.chip ? (b ? 16'h09 : 16'h04) : (b ? 16'h15 : 16'h0a));
    putw(0, r.chip ? 16'hffff : 16'hfffe, b);
    for (int w = 0; w < 4; w++) putw(w + 1, r.crc[16*w+:16], b);
    if (!r.chip) begin
      putw(5, r.start_addr[15:0], b);
      putw(6, r.start_addr[31:16], b);
      putw(7, 16'h0, b);
      putw(8, r.end_addr[15:0], b);
      putw(9, r.end_addr[31:16], b);
      putw(10, 16'h0, b);
    end
    put(0, 16'h29);
    if (fl) put(0, 16'hf0);
  endtask : build
  // One request; a second start mid-run must be ignored when dbl is set.
  task automatic run(fccs_row_t rw, logic dbl);
    int k;
    build(rw.rq, rw.ex[1]);
    if (rw.ex[0]) begin
      ea.delete();
      ed.delete();
    end
    good = rw.good ? rw.rq.crc : ~rw.rq.crc;
    clr = 1'b1;
    req = rw.rq;
    tick();
    clr = 1'b0;
    start = 1'b1;
    tick();
    start = 1'b0;
    if (dbl) begin
      repeat (40) tick();
      req = ~rw.rq;
      start = 1'b1;
      tick();
      start = 1'b0;
    end
    k = 0;
    while (stat.done !== 1'b1 && k < 5000) begin
      tick();
      k++;
    end
    chk("in_time", 64'(k < 5000), 64'h1);
    chk("verdict", {stat.pass, stat.fail, stat.refused}, rw.ex);
    chk("writes", 64'(MDL.n_wr), 64'(ea.size()));
    for (k = 0; k < ea.size(); k++) begin
      chk("addr", MDL.log_a[k], ea[k]);
      chk("data", MDL.log_d[k], ed[k]);
    end
  endtask : run
  function automatic fccs_row_t mk(logic c, logic b, logic g,
      logic [2:0] x, logic [31:0] s, logic [31:0] e);
    mk = {c, b, 64'h0123_4567_89ab_cdef ^ {s, e}, s, e, g, x};
  endfunction : mk
  task automatic report_and_stop;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////
  // Table of requests first, then double start and a reset mid-run.
  initial begin
    srst = 1'b1;
    start = 1'b0;
    clr = 1'b1;
    req = '0;
    good = '0;
    rows[0] = mk(0, 0, 1, 3'b100, 32'h0000_1000, 32'h0000_1fff);
    rows[1] = mk(0, 0, 0, 3'b010, 32'h0000_0000, 32'h0000_0001);
    rows[2] = mk(1, 0, 1, 3'b100, 32'h0000_0005, 32'h0000_0000);
    rows[3] = mk(1, 1, 0, 3'b010, 32'h0000_0000, 32'h0000_0000);
    rows[4] = mk(0, 1, 1, 3'b100, 32'h1234_5678, 32'h7fed_cba9);
    rows[5] = mk(0, 1, 0, 3'b010, 32'h00ab_cdef, 32'hffff_fffe);
    rows[6] = mk(0, 0, 1, 3'b001, 32'h0000_2000, 32'h0000_2000);
    rows[7] = mk(0, 1, 1, 3'b001, 32'h8000_0000, 32'h7fff_ffff);
    repeat (16) tick();
    chk("rst_pins", pins, {4'hf, 23'h0, 16'h0, 16'hffff});
    chk("rst_stat", stat, 5'h0);
    srst = 1'b0;
    foreach (rows[i]) run(rows[i], 1'b0);
    run(rows[4], 1'b1);
    req = rows[0].rq;
    start = 1'b1;
    tick();
    start = 1'b0;
    repeat (60) tick();
    srst = 1'b1;
    repeat (2) tick();
    chk("mid_pins", pins, {4'hf, 23'h0, 16'h0, 16'hffff});
    chk("mid_stat", stat, 5'h0);
    srst = 1'b0;
    run(rows[1], 1'b0);
    report_and_stop();
  end
endmodule : fccs_host_tb
`default_nettype wire
